// File: terminal_char_controller.sv
// Function
// - 0091 function/status, 0090 character data
// - data input fills low byte only
// - data output needs write mode, idle
// - clear controller resets flags, read mode
// - clear interrupt drops requests, manual flag
// - bits 2-4 set data/eop/alarm requests
// - select write clears lost data, unless busy
// - select read refused while busy
// - bit 13 stops echo, bit 10 restores
// - bit 5 zero, spare bits ignored
// - do acceptable functions, reject if none
// - constant status bits 0,8,10,12-15
// - busy while character held in read mode, outbound in write mode
// - interrupt status, eop is not busy
// - data status per mode
// - alarm on lost data or parity
// - overrun sets lost data, locks input
// - parity error and read mode status
// - manual interrupt cleared by clears only
// - status read never rejected
// - requests persist until cleared
// - interrupt on four conditions, level one
// - even parity over eight bits
module terminal_char_controller #(
   parameter int DEPTH = term_pkg::FIFO_DEPTH
) (
   // clocking
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic                ce,
   // processor channel
   input  wire logic                req_valid,
   input  wire term_pkg::chan_req_s req,
   output term_pkg::chan_rsp_s      rsp,
   output logic                     irq_level1,
   // terminal side
   input  wire logic                rx_valid,
   input  wire logic [7:0]          rx_char,
   output logic                     rx_lockout,
   output logic                     tx_valid,
   output logic [7:0]               tx_char,
   input  wire logic                tx_sent,
   output logic                     echo_enable,
   input  wire logic                manual_int
);
   import term_pkg::*;

   logic       rd_mode_q;
   logic       hold_full_q;
   logic [7:0] hold_q;
   logic       lost_q;
   logic       parity_q;
   logic       manual_q;
   logic       req_data_q;
   logic       req_eop_q;
   logic       req_alarm_q;
   logic       echo_q;
   logic       tx_busy_q;
   logic       busy;
   logic       alarm;
   logic       data_st;
   logic       int_cond;
   logic [15:0] status;
   logic       is_func_out;
   logic       is_data_in;
   logic       is_data_out;
   logic       wr_ok;
   logic       mode_ok;
   logic       any_other;
   logic       f_wr;
   logic       f_rd;
   logic       clr_all;
   logic       clr_int;
   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic       push_char;
   logic       pop_char;
   logic       is_stat_in;

   // even parity check across the whole byte
   function automatic logic parity_bad(input logic [7:0] c);
      parity_bad = ^c;
   endfunction : parity_bad

   // address decode of the current instruction
   assign is_func_out = req_valid & ~req.input_instruction & (req.addr == ADDR_FUNC);
   assign is_data_in  = req_valid & req.input_instruction & (req.addr == ADDR_DATA);
   assign is_data_out = req_valid & ~req.input_instruction & (req.addr == ADDR_DATA);
   assign is_stat_in  = req_valid & req.input_instruction & (req.addr == ADDR_FUNC);

   // busy covers a held receive in read mode, or a character still heading to the terminal in write mode
   assign busy    = rd_mode_q ? hold_full_q : (fifo_out_valid | tx_busy_q);
   assign data_st = rd_mode_q ? hold_full_q : (~busy & fifo_in_ready);
   assign alarm   = lost_q | parity_q;
   assign int_cond = (req_data_q & data_st) | (req_eop_q & ~busy)
                   | (req_alarm_q & alarm) | manual_q;

   // refused mode selections are skipped; the rest always run
   assign f_wr      = req.a_reg[FN_WRITE] & ~busy;
   assign f_rd      = req.a_reg[FN_READ] & ~busy;
   assign any_other = req.a_reg[FN_CLR_CTRL] | req.a_reg[FN_CLR_INT] | req.a_reg[FN_DATA_REQ]
                    | req.a_reg[FN_EOP_REQ] | req.a_reg[FN_ALARM_REQ]
                    | req.a_reg[FN_ECHO_ON] | req.a_reg[FN_ECHO_OFF];
   assign mode_ok   = f_wr | f_rd | any_other;
   assign clr_all   = is_func_out & req.a_reg[FN_CLR_CTRL];
   assign clr_int   = is_func_out & req.a_reg[FN_CLR_INT];
   assign wr_ok     = ~rd_mode_q & ~busy & fifo_in_ready;
   assign push_char = ce & is_data_out & wr_ok;
   assign pop_char  = ce & ~tx_busy_q & fifo_out_valid;

   // status word; fixed bits are constants
   always_comb begin
      status            = 16'h0000;
      status[ST_READY]  = 1'b1;
      status[ST_ONE10]  = 1'b1;
      status[ST_BUSY]   = busy;
      status[ST_INT]    = int_cond;
      status[ST_DATA]   = data_st;
      status[ST_EOP]    = ~busy;
      status[ST_ALARM]  = alarm;
      status[ST_LOST]   = lost_q;
      status[ST_PARITY] = parity_q;
      status[ST_RDMODE] = rd_mode_q;
      status[ST_MANUAL] = manual_q;
   end

   // mode register; clear controller forces read unless write also accepted
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_mode_q <= 1'b1;
      end else if (ce && is_func_out) begin
         if (f_wr) rd_mode_q <= 1'b0;
         else if (f_rd || clr_all) rd_mode_q <= 1'b1;
      end
   end

   // receive hold register and its error flags
   always_ff @(posedge clock) begin
      if (rst) begin
         hold_full_q <= 1'b0;
         hold_q      <= 8'h00;
         lost_q      <= 1'b0;
         parity_q    <= 1'b0;
      end else if (ce) begin
         if (clr_all) begin
            hold_full_q <= 1'b0;
            parity_q    <= 1'b0;
            lost_q      <= 1'b0;
         end else if (is_func_out && f_wr) begin
            lost_q <= 1'b0;
         end
         // arrival comes last so a character landing with a clear is kept, not lost
         if (rx_valid && !lost_q && rd_mode_q) begin
            if (hold_full_q && !is_data_in && !clr_all) begin
               lost_q <= 1'b1;
            end else begin
               hold_full_q <= 1'b1;
               hold_q      <= rx_char;
               parity_q    <= parity_bad(rx_char);
            end
         end else if (is_data_in) begin
            hold_full_q <= 1'b0;
         end
      end
   end

   // interrupt requests: a set in the same word beats the clear
   always_ff @(posedge clock) begin
      if (rst) begin
         req_data_q  <= 1'b0;
         req_eop_q   <= 1'b0;
         req_alarm_q <= 1'b0;
      end else if (ce && is_func_out) begin
         if (req.a_reg[FN_DATA_REQ]) req_data_q <= 1'b1;
         else if (clr_all || clr_int) req_data_q <= 1'b0;
         if (req.a_reg[FN_EOP_REQ]) req_eop_q <= 1'b1;
         else if (clr_all || clr_int) req_eop_q <= 1'b0;
         if (req.a_reg[FN_ALARM_REQ]) req_alarm_q <= 1'b1;
         else if (clr_all || clr_int) req_alarm_q <= 1'b0;
      end
   end

   // manual interrupt; a new press wins over a clear in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         manual_q <= 1'b0;
      end else if (ce) begin
         if (manual_int) manual_q <= 1'b1;
         else if (clr_all || clr_int) manual_q <= 1'b0;
      end
   end

   // printer echo; reconnect wins over disconnect if both given
   always_ff @(posedge clock) begin
      if (rst) begin
         echo_q <= 1'b1;
      end else if (ce && is_func_out) begin
         if (req.a_reg[FN_ECHO_ON] || clr_all) echo_q <= 1'b1;
         else if (req.a_reg[FN_ECHO_OFF]) echo_q <= 1'b0;
      end
   end

   // characters to the terminal pass through a FIFO, but writes are refused while busy, so it never holds more than one
   char_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (push_char),
      .in_ready  (fifo_in_ready),
      .in_data   (req.a_reg[7:0]),
      .out_valid (fifo_out_valid),
      .out_ready (~tx_busy_q),
      .out_data  (fifo_out_data)
   );

   // terminal transmit handshake: hold strobe until sent comes back
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_busy_q <= 1'b0;
         tx_char   <= 8'h00;
      end else if (ce) begin
         if (pop_char) begin
            tx_busy_q <= 1'b1;
            tx_char   <= fifo_out_data;
         end else if (tx_sent) begin
            tx_busy_q <= 1'b0;
         end
      end
   end

   // registered channel answer, one cycle after the request
   always_ff @(posedge clock) begin
      if (rst) begin
         rsp        <= '0;
         irq_level1 <= 1'b0;
         rx_lockout <= 1'b0;
         echo_enable <= 1'b1;
      end else if (ce) begin
         irq_level1  <= int_cond;
         rx_lockout  <= lost_q;
         echo_enable <= echo_q;
         rsp.reply   <= 1'b0;
         rsp.reject  <= 1'b0;
         rsp.a_reg   <= req.a_reg;
         if (req_valid) begin
            if (req.addr == ADDR_FUNC) begin
               if (req.input_instruction) begin
                  rsp.reply <= 1'b1;
                  rsp.a_reg <= status;
               end else begin
                  rsp.reply  <= mode_ok;
                  rsp.reject <= ~mode_ok;
               end
            end else if (req.addr == ADDR_DATA) begin
               if (req.input_instruction) begin
                  rsp.reply <= hold_full_q;
                  rsp.reject <= ~hold_full_q;
                  rsp.a_reg <= {req.a_reg[15:8], hold_q};
               end else begin
                  rsp.reply  <= wr_ok;
                  rsp.reject <= ~wr_ok;
               end
            end
         end
      end
   end

   assign tx_valid = tx_busy_q;

   // status word as the processor actually receives it
   eop_inverse_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_stat_in) |=> rsp.a_reg[ST_EOP] != rsp.a_reg[ST_BUSY])
      else $error("eop not inverse of busy");
   status_fixed_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_stat_in) |=> (rsp.a_reg & 16'hf501) == 16'h0401)
      else $error("fixed status bits wrong");
   status_reply_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_stat_in) |=> rsp.reply && !rsp.reject)
      else $error("status read rejected");

   // mode selection and function acceptance
   write_busy_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_func_out && busy && !clr_all) |=> $stable(rd_mode_q))
      else $error("mode changed while busy");
   read_mode_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_func_out && req.a_reg[FN_READ] && !req.a_reg[FN_WRITE] && !busy) |=> rd_mode_q)
      else $error("read mode not selected");
   func_reject_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_func_out && !mode_ok) |=> rsp.reject && !rsp.reply)
      else $error("empty function word not rejected");
   echo_off_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_func_out && req.a_reg[FN_ECHO_OFF] && !req.a_reg[FN_ECHO_ON] && !clr_all) |=> !echo_q)
      else $error("echo not suppressed");

   // receive path; lockout must really freeze the hold register
   lost_set_a: assert property (@(posedge clock) disable iff (rst)
      (ce && rx_valid && rd_mode_q && hold_full_q && !is_data_in && !is_func_out) |=> lost_q)
      else $error("overrun not flagged");
   lock_rx_a: assert property (@(posedge clock) disable iff (rst)
      (ce && lost_q && !is_func_out) |=> $stable(hold_q))
      else $error("input not locked out");
   parity_set_a: assert property (@(posedge clock) disable iff (rst)
      (ce && rx_valid && rd_mode_q && !hold_full_q && !lost_q && ^rx_char) |=> parity_q)
      else $error("odd character not flagged");
   upper_keep_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_data_in) |=> rsp.a_reg[15:8] == $past(req.a_reg[15:8]))
      else $error("upper accumulator byte altered");
   data_in_low_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_data_in && hold_full_q) |=> rsp.reply && rsp.a_reg[7:0] == $past(hold_q))
      else $error("held character not returned");

   // interrupt requests and the level output
   req_set_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_func_out && req.a_reg[FN_DATA_REQ]) |=> req_data_q)
      else $error("data request not set");
   clr_int_a: assert property (@(posedge clock) disable iff (rst)
      (ce && clr_int && !req.a_reg[FN_DATA_REQ]) |=> !req_data_q)
      else $error("request survived clear");
   req_persist_a: assert property (@(posedge clock) disable iff (rst)
      (ce && req_eop_q && !clr_all && !clr_int) |=> req_eop_q)
      else $error("request dropped without clear");
   manual_keep_a: assert property (@(posedge clock) disable iff (rst)
      (ce && manual_q && !clr_all && !clr_int) |=> manual_q)
      else $error("manual flag dropped without clear");
   irq_manual_a: assert property (@(posedge clock) disable iff (rst)
      (ce && manual_q) |=> irq_level1)
      else $error("manual interrupt not raised");
   irq_eop_a: assert property (@(posedge clock) disable iff (rst)
      (ce && req_eop_q && !busy) |=> irq_level1)
      else $error("end of operation interrupt not raised");
   irq_alarm_a: assert property (@(posedge clock) disable iff (rst)
      (ce && req_alarm_q && alarm) |=> irq_level1)
      else $error("alarm interrupt not raised");

   // transmit path
   data_wr_a: assert property (@(posedge clock) disable iff (rst)
      (ce && is_data_out && rd_mode_q) |=> rsp.reject)
      else $error("write accepted in read mode");
   busy_wr_a: assert property (@(posedge clock) disable iff (rst)
      (ce && push_char) |=> busy)
      else $error("busy not raised by write");
   tx_hold_a: assert property (@(posedge clock) disable iff (rst)
      (ce && tx_valid && !tx_sent) |=> tx_valid && $stable(tx_char))
      else $error("terminal strobe not held");
endmodule : terminal_char_controller

// File: term_pkg.sv
package term_pkg;
   // channel addresses
   localparam logic [15:0] ADDR_DATA = 16'h0090;
   localparam logic [15:0] ADDR_FUNC = 16'h0091;
   // function word bit positions
   localparam int FN_CLR_CTRL  = 0;
   localparam int FN_CLR_INT   = 1;
   localparam int FN_DATA_REQ  = 2;
   localparam int FN_EOP_REQ   = 3;
   localparam int FN_ALARM_REQ = 4;
   localparam int FN_WRITE     = 8;
   localparam int FN_READ      = 9;
   localparam int FN_ECHO_ON   = 10;
   localparam int FN_ECHO_OFF  = 13;
   // status word bit positions
   localparam int ST_READY  = 0;
   localparam int ST_BUSY   = 1;
   localparam int ST_INT    = 2;
   localparam int ST_DATA   = 3;
   localparam int ST_EOP    = 4;
   localparam int ST_ALARM  = 5;
   localparam int ST_LOST   = 6;
   localparam int ST_PARITY = 7;
   localparam int ST_RDMODE = 9;
   localparam int ST_ONE10  = 10;
   localparam int ST_MANUAL = 11;
   // buffer depth toward the terminal
   localparam int FIFO_DEPTH = 4;

   // one processor channel request
   typedef struct packed {
      logic        input_instruction;  // 1 = input, 0 = output
      logic [15:0] addr;
      logic [15:0] a_reg;
   } chan_req_s;

   // channel answer
   typedef struct packed {
      logic        reply;
      logic        reject;
      logic [15:0] a_reg;
   } chan_rsp_s;
endpackage : term_pkg

// File: char_fifo.sv
module char_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clocking
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             ce,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : inc

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];
   assign push      = ce & in_valid & in_ready;
   assign pop       = ce & out_valid & out_ready;

   // storage, no reset needed on data
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= inc(wr_q);
         if (pop) rd_q <= inc(rd_q);
         if (push & ~pop) cnt_q <= cnt_q + 1'b1;
         else if (pop & ~push) cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule : char_fifo

// File: cpu_channel_model.sv
// processor side of the channel: one instruction at a time, answer collected
module cpu_channel_model (
   // clocking
   input  wire logic                clock,
   // processor channel
   output logic                     req_valid,
   output term_pkg::chan_req_s      req,
   input  wire term_pkg::chan_rsp_s rsp
);
   timeunit 1ns;
   timeprecision 100ps;
   import term_pkg::*;

   // idle channel at time zero
   initial begin
      req_valid = 1'b0;
      req       = '0;
   end

   // drive after a falling edge, hold one cycle, then look for the answer over two cycles
   task automatic run(input logic i, input logic [15:0] ad, input logic [15:0] a,
                      output logic [1:0] rr, output logic [15:0] ra);
      int k;
      @(negedge clock);
      req_valid             = 1'b1;
      req.input_instruction = i;
      req.addr              = ad;
      req.a_reg             = a;
      if (!i && ad == ADDR_FUNC) begin
         req.a_reg[5] = 1'b0;
      end
      rr = 2'b00;
      ra = 16'h0000;
      @(negedge clock);
      req_valid = 1'b0;
      req       = ~req; // released lines must not look valid
      for (k = 0; k < 2; k++) begin
         if (k == 1) begin
            @(negedge clock);
         end
         if (rr === 2'b00) begin
            rr = {rsp.reply, rsp.reject};
            ra = rsp.a_reg;
         end
      end
   endtask : run
endmodule : cpu_channel_model

// File: test_terminal_char_controller.sv
module test_terminal_char_controller;
   timeunit 1ns;
   timeprecision 100ps;
   import term_pkg::*;

   typedef struct packed {
      logic        i;
      logic [15:0] ad;
      logic [15:0] a;
      logic [1:0]  rr;
      logic [15:0] ex;
      logic [15:0] m;
   } row_s;

   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        req_valid;
   chan_req_s   req;
   chan_rsp_s   rsp;
   logic        irq_level1, rx_lockout, tx_valid, echo_enable;
   logic [7:0]  tx_char;
   logic        rx_valid = 1'b0;
   logic [7:0]  rx_char = 8'h00;
   logic        tx_sent = 1'b0;
   logic        manual_int = 1'b0;
   logic [1:0]  rr;
   logic [15:0] ra;
   int          err_total = 0;
   int          check_count = 0;
   int          cycles = 0;
   // plain cases: read mode after reset, ending with one character queued in write mode
   row_s rows [8] = '{
      '{1'b1, 16'h0091, 16'h0000, 2'b10, 16'h0611, 16'hffff},
      '{1'b0, 16'h0090, 16'h0041, 2'b01, 16'h0000, 16'h0000},
      '{1'b1, 16'h0090, 16'h0000, 2'b01, 16'h0000, 16'h0000},
      '{1'b0, 16'h0092, 16'h0000, 2'b00, 16'h0000, 16'h0000},
      '{1'b0, 16'h0091, 16'hd8c0, 2'b01, 16'h0000, 16'h0000},
      '{1'b0, 16'h0091, 16'h0100, 2'b10, 16'h0000, 16'h0000},
      '{1'b1, 16'h0091, 16'h0000, 2'b10, 16'h0419, 16'hffff},
      '{1'b0, 16'h0090, 16'hab55, 2'b10, 16'hab55, 16'hffff}};

   // 25 ns period
   initial begin
      forever #12.5 clock = ~clock;
   end

   terminal_char_controller i_dut (.clock(clock), .rst(rst), .ce(1'b1), .req_valid(req_valid), .req(req),
      .rsp(rsp), .irq_level1(irq_level1), .rx_valid(rx_valid), .rx_char(rx_char), .rx_lockout(rx_lockout),
      .tx_valid(tx_valid), .tx_char(tx_char), .tx_sent(tx_sent), .echo_enable(echo_enable),
      .manual_int(manual_int));

   cpu_channel_model u_cpu (.clock(clock), .req_valid(req_valid), .req(req), .rsp(rsp));

   task automatic conclude();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g, input logic [15:0] m);
      check_count++;
      if ((g & m) !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g & m);
      end
   endtask : chk

   task automatic chk1(input string n, input logic e, input logic g);
      chk(n, {15'h0000, e}, {15'h0000, g}, 16'hffff);
   endtask : chk1

   // function or data instruction with its expected answer kind
   task automatic op(input logic i, input logic [15:0] ad, input logic [15:0] a, input logic [1:0] e);
      u_cpu.run(i, ad, a, rr, ra);
      chk("answer", {14'h0000, e}, {14'h0000, rr}, 16'hffff);
   endtask : op

   task automatic st(input logic [15:0] e);
      op(1'b1, ADDR_FUNC, 16'h0000, 2'b10);
      chk("status", e, ra, 16'hffff);
   endtask : st

   // bounded waits on registered levels
   task automatic wait_irq(input logic v);
      for (int k = 0; k < 8 && irq_level1 !== v; k++) @(negedge clock);
      chk1("irq", v, irq_level1);
   endtask : wait_irq

   task automatic wait_tx(input logic v);
      for (int k = 0; k < 8 && tx_valid !== v; k++) @(negedge clock);
      chk1("tx_valid", v, tx_valid);
   endtask : wait_tx

   // one received character, line inverted afterwards
   task automatic pulse_rx(input logic [7:0] c);
      @(negedge clock);
      rx_valid = 1'b1;
      rx_char  = c;
      @(negedge clock);
      rx_valid = 1'b0;
      rx_char  = ~c;
   endtask : pulse_rx

   // hang guard, far above the roughly 140 cycles the test is expected to take
   always @(posedge clock) begin
      cycles++;
      if (cycles >= 5000) begin
         err_total++;
         conclude();
      end
   end

   initial begin
      repeat (2) @(negedge clock);
      rst = 1'b0;
      foreach (rows[j]) begin
         u_cpu.run(rows[j].i, rows[j].ad, rows[j].a, rr, ra);
         chk("row answer", {14'h0000, rows[j].rr}, {14'h0000, rr}, 16'hffff);
         chk("row value", rows[j].ex, ra, rows[j].m);
      end
      // write in flight with the terminal stalling
      wait_tx(1'b1);
      chk("tx_char", 16'h0055, {8'h00, tx_char}, 16'hffff);
      st(16'h0403);
      op(1'b0, ADDR_DATA, 16'h0066, 2'b01);
      op(1'b0, ADDR_FUNC, 16'h0200, 2'b01);
      op(1'b0, ADDR_FUNC, 16'h0208, 2'b10);
      st(16'h0403);
      chk1("irq busy", 1'b0, irq_level1);
      chk1("tx held", 1'b1, tx_valid);
      @(negedge clock) tx_sent = 1'b1;
      @(negedge clock) tx_sent = 1'b0;
      wait_tx(1'b0);
      wait_irq(1'b1);
      st(16'h041d);
      op(1'b0, ADDR_FUNC, 16'h0002, 2'b10);
      wait_irq(1'b0);
      st(16'h0419);
      // read mode: receive, parity fault, overrun
      op(1'b0, ADDR_FUNC, 16'h0204, 2'b10);
      st(16'h0611);
      pulse_rx(8'h41);
      wait_irq(1'b1);
      st(16'h060f);
      u_cpu.run(1'b1, ADDR_DATA, 16'hcd00, rr, ra);
      chk("data in", 16'hcd41, ra, 16'hffff);
      wait_irq(1'b0);
      st(16'h0611);
      pulse_rx(8'h43);
      st(16'h06af);
      pulse_rx(8'h41);
      st(16'h06ef);
      chk1("lockout", 1'b1, rx_lockout);
      op(1'b0, ADDR_FUNC, 16'h0001, 2'b10);
      st(16'h0611);
      chk1("lockout clr", 1'b0, rx_lockout);
      // alarm request alone stays quiet until a parity fault arrives
      op(1'b0, ADDR_FUNC, 16'h0010, 2'b10);
      chk1("irq no alarm", 1'b0, irq_level1);
      pulse_rx(8'h43);
      wait_irq(1'b1);
      st(16'h06af);
      op(1'b0, ADDR_FUNC, 16'h0001, 2'b10);
      wait_irq(1'b0);
      // manual interrupt survives other traffic
      @(negedge clock) manual_int = 1'b1;
      @(negedge clock) manual_int = 1'b0;
      wait_irq(1'b1);
      st(16'h0e15);
      op(1'b1, ADDR_DATA, 16'h0000, 2'b01);
      st(16'h0e15);
      op(1'b0, ADDR_FUNC, 16'h0002, 2'b10);
      wait_irq(1'b0);
      st(16'h0611);
      // echo control
      op(1'b0, ADDR_FUNC, 16'h2000, 2'b10);
      chk1("echo off", 1'b0, echo_enable);
      op(1'b0, ADDR_FUNC, 16'h0400, 2'b10);
      chk1("echo on", 1'b1, echo_enable);
      // reset in mid-run with a character on its way out
      op(1'b0, ADDR_FUNC, 16'h2100, 2'b10);
      op(1'b0, ADDR_DATA, 16'h0041, 2'b10);
      chk1("tx before rst", 1'b1, tx_valid);
      @(negedge clock) rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      chk1("echo rst", 1'b1, echo_enable);
      chk1("tx rst", 1'b0, tx_valid);
      st(16'h0611);
      conclude();
   end
endmodule : test_terminal_char_controller
